// File: rtl/ced_pkg.sv
// Shared types and constants of the CAN error detection and fault confinement block.
package ced_pkg;

   // Frame field that the framer reports for the bit now at the sample point.
   typedef enum logic [3:0] {
      FLD_IDLE     = 4'b0000, // Bus idle, no frame in progress.
      FLD_SOF      = 4'b0001, // Start-of-frame bit.
      FLD_ARB      = 4'b0010, // Arbitration field.
      FLD_CTRL     = 4'b0011, // Control field.
      FLD_DATA     = 4'b0100, // Data field.
      FLD_CRC      = 4'b0101, // CRC sequence.
      FLD_CRC_DLM  = 4'b0110, // CRC delimiter.
      FLD_ACK_SLOT = 4'b0111, // Acknowledge slot.
      FLD_ACK_DLM  = 4'b1000, // Acknowledge delimiter.
      FLD_EOF      = 4'b1001, // End-of-frame field.
      FLD_IFS      = 4'b1010, // Interframe space.
      FLD_ERRF     = 4'b1011  // Error frame in progress.
   } ced_field_t;

   // Fault confinement state.
   typedef enum logic [1:0] {
      ST_ACTIVE  = 2'b00, // Error-active.
      ST_PASSIVE = 2'b01, // Error-passive.
      ST_BUS_OFF = 2'b10  // Bus-off.
   } ced_state_t;

   // Per-bit information from the framer, valid while the sample enable is high.
   typedef struct packed {
      ced_field_t field;        // Field of the current bit.
      logic       tx_bit;       // Level this node drives, 1 is recessive.
      logic       transmitting; // This node is the transmitter of the frame.
      logic       stuff_bit;    // Current bit is a stuff bit.
   } ced_bit_t;

   // Error kinds found on one bit.
   typedef struct packed {
      logic bit_e;   // Bit error.
      logic stuff_e; // Stuff error.
      logic crc_e;   // CRC error.
      logic form_e;  // Form error.
      logic ack_e;   // Acknowledge error.
   } ced_err_t;

   localparam logic [2:0]  STUFF_RUN      = 3'h6;     // Equal bits that break stuffing.
   localparam int          CRC_W          = 15;       // CRC width.
   localparam logic [14:0] CRC_POLY       = 15'h4599; // CAN CRC-15 polynomial.
   localparam logic [14:0] CRC_INIT       = 15'h0000; // CRC start value.
   localparam logic [8:0]  TEC_INC        = 9'h008;   // Transmit error step.
   localparam logic [7:0]  REC_INC        = 8'h01;    // Receive error step.
   localparam logic [8:0]  PASSIVE_LIMIT  = 9'h07f;   // Passive above this count.
   localparam logic [8:0]  BUS_OFF_LIMIT  = 9'h0ff;   // Bus-off above this count.
   localparam logic [7:0]  REC_RESTORE    = 8'h78;    // REC after success while REC is above the passive limit.
   localparam logic [3:0]  RECOVERY_BITS  = 4'hb;     // Recessive bits per idle run.
   localparam logic [7:0]  RECOVERY_RUNS  = 8'h80;    // Idle runs to leave bus-off.

endpackage : ced_pkg

// File: rtl/ced_confine.sv
`timescale 1ns/1ps
`default_nettype none
// Error counters and the three-state fault confinement machine.
module ced_confine
   import ced_pkg::*;
(
   input  wire logic       clk_sys_in,          // System clock.
   input  wire logic       rst_n_in,            // Synchronous reset, active low.
   input  wire logic       sample_en_in,        // One pulse per bit at the sample point.
   input  wire logic       rx_bit_in,           // Synchronised bus level.
   input  wire logic       rx_err_in,           // Error seen while receiving.
   input  wire logic       tx_err_in,           // Error seen while transmitting.
   input  wire logic       rx_ok_in,            // Frame received without error.
   input  wire logic       tx_ok_in,            // Frame transmitted without error.
   output logic [7:0]      rec_out,             // Receive error count.
   output logic [8:0]      tec_out,             // Transmit error count.
   output ced_state_t      state_out            // Fault confinement state.
);

   logic [7:0] rec_q;   // Receive error counter.
   logic [8:0] tec_q;   // Transmit error counter, nine bits to see the bus-off step.
   ced_state_t state_q; // Current state.
   logic [3:0] run_q;   // Recessive bits in the current idle run.
   logic [7:0] runs_q;  // Completed idle runs while bus-off.
   logic       recovered; // Bus-off recovery complete this cycle.

   assign recovered = sample_en_in && rx_bit_in && (run_q == RECOVERY_BITS - 4'h1)
                      && (runs_q == RECOVERY_RUNS - 8'h01) && (state_q == ST_BUS_OFF);

   // Receive counter: step up on errors, down on success, saturating at both ends.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || recovered) begin
         rec_q <= 8'h00;
      end else if (state_q == ST_BUS_OFF) begin
         rec_q <= rec_q; // Bus-off freezes reception counting.
      end else if (rx_err_in) begin
         if (rec_q != 8'hff) rec_q <= rec_q + REC_INC;
      end else if (rx_ok_in) begin
         if (rec_q > PASSIVE_LIMIT[7:0]) rec_q <= REC_RESTORE;
         else if (rec_q != 8'h00) rec_q <= rec_q - REC_INC;
      end
   end

   // Transmit counter: plus eight on error, minus one on success.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || recovered) begin
         tec_q <= 9'h000;
      end else if (state_q == ST_BUS_OFF) begin
         tec_q <= tec_q;
      end else if (tx_err_in) begin
         tec_q <= tec_q + TEC_INC;
      end else if (tx_ok_in && tec_q != 9'h000) begin
         tec_q <= tec_q - 9'h001;
      end
   end

   // State follows the counters; bus-off is left only by the recovery sequence.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || recovered) begin
         state_q <= ST_ACTIVE;
      end else begin
         case (state_q)
            ST_BUS_OFF: begin
               state_q <= ST_BUS_OFF;
            end
            default: begin
               if (tec_q > BUS_OFF_LIMIT) state_q <= ST_BUS_OFF;
               else if (tec_q > PASSIVE_LIMIT || {1'b0, rec_q} > PASSIVE_LIMIT) begin
                  state_q <= ST_PASSIVE;
               end else state_q <= ST_ACTIVE;
            end
         endcase
      end
   end

   // Recovery counts runs of recessive bits; a dominant bit restarts the run only.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in || state_q != ST_BUS_OFF || recovered) begin
         run_q  <= 4'h0;
         runs_q <= 8'h00;
      end else if (sample_en_in) begin
         if (!rx_bit_in) begin
            run_q <= 4'h0;
         end else if (run_q == RECOVERY_BITS - 4'h1) begin
            run_q  <= 4'h0;
            runs_q <= runs_q + 8'h01;
         end else begin
            run_q <= run_q + 4'h1;
         end
      end
   end

   assign rec_out   = rec_q;
   assign tec_out   = tec_q;
   assign state_out = state_q;

   AST_TEC_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      tx_err_in && state_q != ST_BUS_OFF |=> tec_q == $past(tec_q) + TEC_INC)
      else $error("Transmit counter did not step by eight.");
   AST_BUS_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state_q != ST_BUS_OFF && tec_q > BUS_OFF_LIMIT |=> state_q == ST_BUS_OFF)
      else $error("Bus-off not entered above the limit.");
   AST_PASSIVE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state_q == ST_ACTIVE && !recovered && tec_q <= BUS_OFF_LIMIT
      && (tec_q > PASSIVE_LIMIT || {1'b0, rec_q} > PASSIVE_LIMIT) |=> state_q == ST_PASSIVE)
      else $error("Error-passive not entered above the limit.");
   AST_ONE_STATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state_q inside {ST_ACTIVE, ST_PASSIVE, ST_BUS_OFF})
      else $error("Confinement state is not one of the three.");
   COV_BUS_OFF: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state_q == ST_PASSIVE ##1 state_q == ST_BUS_OFF);

endmodule : ced_confine
`default_nettype wire

// File: rtl/ced_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Transmitter sends recessive ACK, checks dominant.
// - No dominant ACK: error frame, retransmit.
// - Dominant in fixed delimiters or EOF: form error.
// - Transmitter flags read-back mismatch as bit error.
// - Recessive overwritten in arbitration or ACK: fine.
// - Six equal bits SOF to CRC delimiter: stuff error.
// - Any error: error frame; transmitter errors also abort, retransmit.
// - Exactly one of three states from counters.
// - Error-active: free transmit, dominant error flags.
// - Error-passive: transmit, recessive error flags only.
// - Bus-off: neither receive nor transmit.
// - Separate readable receive and transmit counters.
// - Counters follow CAN increment and decrement rules.
// - Receiver checks CRC, mismatch is CRC error.
module ced_detect
   import ced_pkg::*;
(
   input  wire logic       clk_sys_in,               // System clock.
   input  wire logic       rst_n_in,                 // Synchronous reset, active low.
   input  wire logic       rx_pin_in,                // Bus level from the receive pin.
   input  wire logic       sample_en_in,             // One pulse per bit at the sample point.
   input  wire ced_bit_t   bit_info_in,              // Framer view of the current bit.
   output logic            error_frame_out,          // Pulse: start an error frame.
   output logic            passive_flag_out,         // Level: error flag must be recessive.
   output logic            abort_tx_out,             // Pulse: abort the running transmission.
   output logic            retransmit_out,           // Pulse: queue the frame again.
   output logic            participate_out,          // Level: node may use the bus.
   output ced_err_t        err_kind_out,             // Kinds of the last error, registered.
   output logic [7:0]      receive_error_count_out,  // Receive error counter.
   output logic [8:0]      transmit_error_count_out, // Transmit error counter.
   output ced_state_t      error_state_out           // Fault confinement state.
);

   logic        rx_meta_q;    // First synchroniser stage.
   logic        rx_q;         // Second synchroniser stage, the bus level used below.
   logic [2:0]  same_cnt_q;   // Run length of equal bits in the stuffed region.
   logic        last_bit_q;   // Previous bus level in the stuffed region.
   logic [14:0] crc_q;        // Running CRC of the received frame.
   logic        frame_err_q;  // An error has been seen in the current frame.
   ced_field_t  prev_field_q; // Field of the previous bit.
   ced_err_t    err_now;      // Errors found on this bit.
   ced_err_t    err_kind_q;   // Held copy of the last error kinds.
   logic        any_err;      // Some error this bit while on the bus.
   logic        err_pulse_q;  // Registered error frame request.
   logic        abort_q;      // Registered abort request.
   logic        retx_q;       // Registered retransmit request.
   logic        rx_ok;        // Frame received cleanly this bit.
   logic        tx_ok;        // Frame transmitted cleanly this bit.
   logic        in_stuffed;   // Bit is between SOF and the CRC delimiter.
   logic        in_crc;       // Bit feeds the CRC check.
   logic        in_frame;     // Bit belongs to a data or remote frame.
   logic        txing;        // Shorthand for the transmitter flag.
   logic        sent;         // Shorthand for the level driven.
   ced_state_t  state;        // State from the confinement unit.
   logic [7:0]  rec;          // Receive counter from the confinement unit.
   logic [8:0]  tec;          // Transmit counter from the confinement unit.

   // One CRC-15 step; applying it through the CRC field leaves zero on a good frame.
   function automatic logic [14:0] crc_step(input logic [14:0] crc, input logic b);
      logic fb;
      fb = crc[14] ^ b;
      crc_step = {crc[13:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
   endfunction : crc_step

   // The pin is asynchronous to the system clock, so it passes two flip-flops.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         rx_meta_q <= 1'b1;
         rx_q      <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin_in;
         rx_q      <= rx_meta_q;
      end
   end

   assign txing      = bit_info_in.transmitting;
   assign sent       = bit_info_in.tx_bit;
   assign in_stuffed = bit_info_in.field inside {FLD_SOF, FLD_ARB, FLD_CTRL, FLD_DATA,
                                                 FLD_CRC, FLD_CRC_DLM};
   assign in_crc     = bit_info_in.field inside {FLD_SOF, FLD_ARB, FLD_CTRL, FLD_DATA,
                                                 FLD_CRC} && !bit_info_in.stuff_bit;
   assign in_frame   = in_stuffed || bit_info_in.field inside {FLD_ACK_SLOT, FLD_ACK_DLM,
                                                              FLD_EOF};

   // Error checks on the sampled bit; recessive is a one on the bus.
   always_comb begin
      err_now = '0;
      if (sample_en_in) begin
         // A sent recessive bit read back dominant is only an error outside
         // arbitration and the ACK slot, where losing or being acked is normal.
         err_now.bit_e = txing && in_frame && (sent != rx_q)
                         && !(sent && !rx_q && bit_info_in.field inside
                              {FLD_ARB, FLD_ACK_SLOT});
         err_now.stuff_e = in_stuffed && bit_info_in.field != FLD_SOF
                           && rx_q == last_bit_q
                           && same_cnt_q == STUFF_RUN - 3'h1;
         err_now.ack_e = txing && bit_info_in.field == FLD_ACK_SLOT && rx_q;
         err_now.form_e = !rx_q && bit_info_in.field inside
                          {FLD_CRC_DLM, FLD_ACK_DLM, FLD_EOF, FLD_IFS};
         err_now.crc_e = !txing && bit_info_in.field == FLD_CRC_DLM
                         && crc_q != CRC_INIT;
      end
   end

   // Bus-off takes the node off the bus, so nothing it sees counts as an error.
   assign any_err = (|err_now) && state != ST_BUS_OFF;

   // Run-length counter for the stuffing rule, restarted at every start-of-frame.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         same_cnt_q <= 3'h0;
         last_bit_q <= 1'b1;
      end else if (sample_en_in && in_stuffed) begin
         if (bit_info_in.field == FLD_SOF || rx_q != last_bit_q) begin
            same_cnt_q <= 3'h1;
         end else if (same_cnt_q != STUFF_RUN) begin
            same_cnt_q <= same_cnt_q + 3'h1;
         end
         last_bit_q <= rx_q;
      end
   end

   // Receiver CRC over SOF to the end of the CRC field, stuff bits left out.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         crc_q <= CRC_INIT;
      end else if (sample_en_in && in_crc) begin
         if (bit_info_in.field == FLD_SOF) crc_q <= crc_step(CRC_INIT, rx_q);
         else crc_q <= crc_step(crc_q, rx_q);
      end
   end

   // Frame bookkeeping: an error marks the frame, SOF clears the mark.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         frame_err_q  <= 1'b0;
         prev_field_q <= FLD_IDLE;
      end else if (sample_en_in) begin
         prev_field_q <= bit_info_in.field;
         if (any_err) frame_err_q <= 1'b1; // Setting wins over the SOF clear.
         else if (bit_info_in.field == FLD_SOF) frame_err_q <= 1'b0;
      end
   end

   // The frame counts as good once EOF has ended cleanly.
   assign rx_ok = sample_en_in && prev_field_q == FLD_EOF && bit_info_in.field != FLD_EOF
                  && !frame_err_q && !any_err && !txing;
   assign tx_ok = sample_en_in && prev_field_q == FLD_EOF && bit_info_in.field != FLD_EOF
                  && !frame_err_q && !any_err && txing;

   // Error reaction: flag the error; a transmitter also aborts and queues the frame once more.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         err_pulse_q <= 1'b0;
         abort_q     <= 1'b0;
         retx_q      <= 1'b0;
         err_kind_q  <= '0;
      end else begin
         err_pulse_q <= any_err;
         abort_q     <= any_err && txing;
         retx_q      <= any_err && txing;
         if (any_err) err_kind_q <= err_now;
      end
   end

   ced_confine u_confine (
      .clk_sys_in   (clk_sys_in),
      .rst_n_in     (rst_n_in),
      .sample_en_in (sample_en_in),
      .rx_bit_in    (rx_q),
      .rx_err_in    (any_err && !txing),
      .tx_err_in    (any_err && txing),
      .rx_ok_in     (rx_ok),
      .tx_ok_in     (tx_ok),
      .rec_out      (rec),
      .tec_out      (tec),
      .state_out    (state)
   );

   assign error_frame_out          = err_pulse_q;
   assign abort_tx_out             = abort_q;
   assign retransmit_out           = retx_q;
   assign passive_flag_out         = (state != ST_ACTIVE);
   assign participate_out          = (state != ST_BUS_OFF);
   assign err_kind_out             = err_kind_q;
   assign receive_error_count_out  = rec;
   assign transmit_error_count_out = tec;
   assign error_state_out          = state;

   AST_ACK_ERR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && txing && bit_info_in.field == FLD_ACK_SLOT && rx_q
      && state != ST_BUS_OFF |=> error_frame_out && retransmit_out && err_kind_out.ack_e)
      else $error("Missing ACK did not raise an error frame.");
   AST_ACK_OK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && txing && bit_info_in.field == FLD_ACK_SLOT && sent && !rx_q
      |-> !err_now.ack_e && !err_now.bit_e)
      else $error("Dominant ACK was treated as an error.");
   AST_FORM: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && !rx_q && bit_info_in.field inside {FLD_EOF, FLD_ACK_DLM}
      && state != ST_BUS_OFF |=> error_frame_out && err_kind_out.form_e)
      else $error("Dominant delimiter did not raise a form error.");
   AST_BIT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && txing && bit_info_in.field == FLD_DATA && sent != rx_q
      && state != ST_BUS_OFF |=> error_frame_out ##0 abort_tx_out)
      else $error("Read-back mismatch did not raise a bit error.");
   AST_ARB_LOSS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && txing && bit_info_in.field == FLD_ARB && sent && !rx_q
      |-> !err_now.bit_e)
      else $error("Lost arbitration was flagged as a bit error.");
   AST_STUFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      sample_en_in && in_stuffed && bit_info_in.field != FLD_SOF && rx_q == last_bit_q
      && same_cnt_q == 3'h5 |-> err_now.stuff_e)
      else $error("Sixth equal bit did not raise a stuff error.");
   // The flag is checked one cycle on, since error_frame_out is the registered any_err of the bus-off cycle.
   AST_BUS_OFF_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state == ST_BUS_OFF |-> !participate_out ##1 !error_frame_out)
      else $error("Bus-off node still takes part.");
   AST_PASSIVE_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      state == ST_PASSIVE |-> passive_flag_out && participate_out)
      else $error("Error-passive node would send dominant flags.");
   COV_ACK_ERR: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      error_frame_out && err_kind_out.ack_e);
   COV_CRC_ERR: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      error_frame_out && err_kind_out.crc_e);
   COV_TX_OK: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) tx_ok);

endmodule : ced_detect
`default_nettype wire

// File: verification/ced_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for the other nodes on the shared bus.
module ced_bus_node (
   input  wire logic node_tx_in,  // Level this node drives, 1 is recessive.
   input  wire logic peer_dom_in, // Another node drives a dominant bit.
   output logic      bus_out      // Resulting bus level seen at the pin.
);
   // The bus is a wired-AND, so any dominant driver wins the line.
   // Peers acknowledge or overwrite bits only when a scenario asks them to.
   assign bus_out = node_tx_in & ~peer_dom_in;
endmodule : ced_bus_node
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ced_pkg::*;
   logic       clk_sys_in;         // System clock.
   logic       rst_n_in;           // Synchronous reset, active low.
   logic       sample_en_in;       // Bit sample strobe.
   logic       peer_dom;           // Peers pull the bus dominant.
   logic       rx_pin;             // Bus level back at the pin.
   ced_bit_t   bit_info;           // Framer view of the bit.
   logic       ef_out, pf_out, ab_out, rt_out, pa_out;
   ced_err_t   ek_out;             // Kinds of the last error.
   logic [7:0] rec;                // Receive error count.
   logic [8:0] tec;                // Transmit error count.
   ced_state_t st;                 // Confinement state.
   logic       ef_seen = 1'b0;     // Sticky: an error frame was requested.
   logic       ar_seen = 1'b0;     // Sticky: abort and retransmit came together.
   int         bad_count = 0;      // Mismatches.
   int         n_compared = 0;     // Comparisons.
   ced_field_t flds [4] = '{FLD_CRC_DLM, FLD_ACK_DLM, FLD_EOF, FLD_IFS};

   // Our node only drives the bus while it is the transmitter.
   ced_bus_node i_bus (.node_tx_in(bit_info.tx_bit | ~bit_info.transmitting),
      .peer_dom_in(peer_dom), .bus_out(rx_pin));
   ced_detect i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .rx_pin_in(rx_pin),
      .sample_en_in(sample_en_in), .bit_info_in(bit_info), .error_frame_out(ef_out),
      .passive_flag_out(pf_out), .abort_tx_out(ab_out), .retransmit_out(rt_out),
      .participate_out(pa_out), .err_kind_out(ek_out), .receive_error_count_out(rec),
      .transmit_error_count_out(tec), .error_state_out(st));

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end

   // Pulses last one cycle, so they are latched here rather than polled.
   always @(posedge clk_sys_in) begin
      if (ef_out === 1'b1) ef_seen <= 1'b1;
      if (ab_out === 1'b1 && rt_out === 1'b1) ar_seen <= 1'b1;
   end

   task summarize;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Reset is held for two edges; the pin synchroniser itself resets to recessive.
   task do_reset;
      rst_n_in = 1'b0;
      sample_en_in = 1'b0;
      peer_dom = 1'b0;
      bit_info = '{FLD_IDLE, 1'b1, 1'b0, 1'b0};
      repeat (2) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
   endtask : do_reset

   // One bit: the level needs two edges to pass the synchroniser before sampling.
   task send_bit(input ced_field_t f, input logic tx, input logic txing, input logic dom);
      bit_info = '{f, tx, txing, 1'b0};
      peer_dom = dom;
      ef_seen = 1'b0;
      ar_seen = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      sample_en_in = 1'b1;
      @(negedge clk_sys_in);
      sample_en_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
   endtask : send_bit

   task t_ack;
      do_reset;
      send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      chk(ef_seen, 1'b1);
      chk(ar_seen, 1'b1);
      chk(ek_out, 5'h01);
      chk(tec, 9'h008);
      send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b1);
      chk(ef_seen, 1'b0);
      $display("acknowledge test done");
   endtask : t_ack

   task t_form_bit;
      do_reset;
      foreach (flds[i]) begin
         send_bit(flds[i], 1'b1, 1'b0, 1'b1);
         chk(ef_seen, 1'b1);
         chk(ek_out.form_e, 1'b1);
         chk(ar_seen, 1'b0);
         chk(rec, 8'(i + 1));
      end
      do_reset;
      send_bit(FLD_ARB, 1'b1, 1'b1, 1'b1);
      chk(ef_seen, 1'b0);
      send_bit(FLD_DATA, 1'b1, 1'b1, 1'b1);
      chk(ek_out.bit_e, 1'b1);
      chk(ar_seen, 1'b1);
      $display("form and bit test done");
   endtask : t_form_bit

   task t_stuff_crc;
      do_reset;
      send_bit(FLD_SOF, 1'b1, 1'b0, 1'b1);
      repeat (4) send_bit(FLD_ARB, 1'b1, 1'b0, 1'b1);
      chk(ef_seen, 1'b0);
      send_bit(FLD_ARB, 1'b1, 1'b0, 1'b1);
      chk(ek_out.stuff_e, 1'b1);
      // A recessive data bit leaves a non-zero remainder; a dominant one leaves zero.
      for (int b = 0; b < 2; b++) begin
         do_reset;
         send_bit(FLD_SOF, 1'b1, 1'b0, 1'b1);
         send_bit(FLD_DATA, 1'b1, 1'b0, b[0]);
         send_bit(FLD_CRC_DLM, 1'b1, 1'b0, 1'b0);
         chk(ef_seen, !b[0]);
         chk(ek_out.crc_e, !b[0]);
      end
      $display("stuff and crc test done");
   endtask : t_stuff_crc

   task t_confine;
      do_reset;
      send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      // A clean frame afterwards lowers the transmit count by one.
      send_bit(FLD_SOF, 1'b0, 1'b1, 1'b0);
      send_bit(FLD_ARB, 1'b1, 1'b1, 1'b0);
      send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b1);
      foreach (flds[i]) if (i > 0) send_bit(flds[i], 1'b1, 1'b1, 1'b0);
      chk(tec, 9'h007);
      do_reset;
      repeat (15) send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      chk(st, ST_ACTIVE);
      chk(pf_out, 1'b0);
      send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      chk(st, ST_PASSIVE);
      chk(pf_out, 1'b1);
      repeat (16) send_bit(FLD_ACK_SLOT, 1'b1, 1'b1, 1'b0);
      chk(tec, 9'h100);
      chk(st, ST_BUS_OFF);
      chk(pa_out, 1'b0);
      send_bit(FLD_DATA, 1'b1, 1'b1, 1'b1);
      chk(ef_seen, 1'b0);
      $display("confinement test done");
   endtask : t_confine

   // The run needs well under 2000 cycles; this span leaves a wide margin.
   initial begin
      #100us;
      bad_count++;
      $display("watchdog expired");
      summarize;
   end

   initial begin
      do_reset;
      t_ack;
      t_form_bit;
      t_stuff_crc;
      t_confine;
      summarize;
   end
endmodule : tb_top
`default_nettype wire
